/* File: sck_pkg.sv */
// Package of the command and power-state logic: timing counts, widths,
// reset values, power states and the decoded command set.
// Assumes one 10 MHz clock; all counts below are in cycles of that clock.
package sck_pkg;

    localparam int CLK_PERIOD_NS = 100;

    // Timing windows in nanoseconds; plain defaults.
    localparam int TRP_NS = 15;
    localparam int TRFC_NS = 350;
    localparam int TXP_NS = 24;
    localparam int TXS_NS = 360;
    localparam int ZQINIT_NS = 51200;
    localparam int ZQOPER_NS = 25600;

    localparam int TMR_N = 5;
    localparam int TMR_W = 16;
    localparam int TMR_BURST = 0;
    localparam int TMR_PRE = 1;
    localparam int TMR_REF = 2;
    localparam int TMR_ZQ = 3;
    localparam int TMR_EXIT = 4;

    localparam int NBANK = 8;
    localparam int NMR = 4;
    localparam int BA_W = 3;
    localparam int MR_SEL_W = 2;
    localparam int ADDR_W = 16;
    localparam int A10_POS = 10;

    // A minimum time rounds up to whole cycles and never below one.
    function automatic logic [TMR_W-1:0] ns_to_cyc(input int ns);
        int cyc;
        cyc = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        if (cyc < 1)
        begin
            cyc = 1;
        end
        return TMR_W'(cyc);
    endfunction : ns_to_cyc

    localparam logic [TMR_W-1:0] TRP_CYC = ns_to_cyc(TRP_NS);
    localparam logic [TMR_W-1:0] TRFC_CYC = ns_to_cyc(TRFC_NS);
    localparam logic [TMR_W-1:0] TXP_CYC = ns_to_cyc(TXP_NS);
    localparam logic [TMR_W-1:0] TXS_CYC = ns_to_cyc(TXS_NS);
    localparam logic [TMR_W-1:0] ZQINIT_CYC = ns_to_cyc(ZQINIT_NS);
    localparam logic [TMR_W-1:0] ZQOPER_CYC = ns_to_cyc(ZQOPER_NS);
    // A BL8 burst occupies four clocks of the data bus.
    localparam logic [TMR_W-1:0] BURST_CYC = 16'h0004;

    localparam logic [NBANK-1:0] BANK_RST = 8'h00;
    localparam logic [ADDR_W-1:0] MR_RST = 16'h0000;
    localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;

    typedef enum logic [2:0] {
        PWR_NORMAL,
        PWR_PD_ACTIVE,
        PWR_PD,
        PWR_PD_PRECH,
        PWR_SREF
    } sck_pwr_t;

    typedef enum logic [3:0] {
        CMD_DES,
        CMD_NOP,
        CMD_MRS,
        CMD_REF,
        CMD_PRE,
        CMD_ACT,
        CMD_WR,
        CMD_RD,
        CMD_ZQCL,
        CMD_ZQCS
    } sck_cmd_t;

    function automatic sck_cmd_t decode_cmd(input logic cs_n, input logic ras_n,
                                            input logic cas_n, input logic we_n,
                                            input logic a10);
        sck_cmd_t c;
        c = CMD_NOP;
        if (cs_n)
        begin
            c = CMD_DES;
        end
        else
        begin
            case ({ras_n, cas_n, we_n})
                3'h0: c = CMD_MRS;
                3'h1: c = CMD_REF;
                3'h2: c = CMD_PRE;
                3'h3: c = CMD_ACT;
                3'h4: c = CMD_WR;
                3'h5: c = CMD_RD;
                3'h6: c = a10 ? CMD_ZQCL : CMD_ZQCS;
                default: c = CMD_NOP;
            endcase
        end
        return c;
    endfunction : decode_cmd

endpackage : sck_pkg

/* File: sck_tmr_if.sv */
// Interface between the command logic and its bank of down-counters.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface sck_tmr_if #(parameter int N = 5, parameter int W = 16);
    logic [N-1:0] start;
    logic [N-1:0][W-1:0] load;
    logic [N-1:0] busy;
    logic [N-1:0] done;

    modport ctl (output start, output load, input busy, input done);
    modport tmr (input start, input load, output busy, output done);
endinterface : sck_tmr_if
`default_nettype wire

/* File: sck_timer_bank.sv */
// Bank of independent down-counters that time bursts, precharge, refresh,
// calibration and power-state exit.
// Assumes start pulses come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sck_timer_bank
    import sck_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic srst_i,
    sck_tmr_if.tmr tb
);

    logic [TMR_N-1:0][TMR_W-1:0] cnt_reg;
    logic [TMR_N-1:0][TMR_W-1:0] cnt_next;

    // A start reloads the counter even while it is still running.
    always_comb
    begin
        for (int i = 0; i < TMR_N; i++)
        begin
            if (tb.start[i])
            begin
                cnt_next[i] = tb.load[i];
            end
            else if (cnt_reg[i] != TMR_RST)
            begin
                cnt_next[i] = cnt_reg[i] - 16'h0001;
            end
            else
            begin
                cnt_next[i] = TMR_RST;
            end
            tb.busy[i] = (cnt_reg[i] != TMR_RST);
            tb.done[i] = (cnt_reg[i] == 16'h0001);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_reg <= '0;
        end
        else if (srst_i)
        begin
            cnt_reg <= '0;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end

endmodule : sck_timer_bank
`default_nettype wire

/* File: sck_cmd_state.sv */
// Command qualification and clock-enable power-state logic of the DRAM core.
// Assumes the controller drives the command pins from logic on CLK_I.
`timescale 1ns/1ps
`default_nettype none
module sck_cmd_state
    import sck_pkg::*;
(
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic DRAM_RST_N_I,
    input wire logic CKE_I,
    input wire logic CS_N_I,
    input wire logic RAS_N_I,
    input wire logic CAS_N_I,
    input wire logic WE_N_I,
    input wire logic [sck_pkg::BA_W-1:0] BA_I,
    input wire logic [sck_pkg::ADDR_W-1:0] ADDR_I,
    output var sck_pkg::sck_pwr_t PWR_STATE_O,
    output logic [sck_pkg::NBANK-1:0] BANK_OPEN_O,
    output logic BURST_ACT_O,
    output logic REFRESH_ACT_O,
    output logic ZQ_BUSY_O,
    output logic CAL_APPLY_O,
    output logic IDLE_O,
    output logic CMD_TAKEN_O,
    output logic ILLEGAL_O,
    output logic [sck_pkg::NMR*sck_pkg::ADDR_W-1:0] MODE_REG_O
);

    import sck_pkg::*;

    sck_tmr_if #(.N(TMR_N), .W(TMR_W)) tmr_bus ();

    sck_pwr_t st_reg;
    sck_pwr_t st_next;
    sck_cmd_t cmd;
    logic desnop;
    logic all_idle;
    logic cke_prev_reg;
    logic cke_meta_reg;
    logic cke_sync_reg;
    logic cke_sync_d_reg;
    logic [NBANK-1:0] bank_reg;
    logic [NBANK-1:0] bank_next;
    logic [NBANK-1:0] ap_reg;
    logic [NBANK-1:0] ap_next;
    logic [NMR-1:0][ADDR_W-1:0] mr_reg;
    logic [NMR-1:0][ADDR_W-1:0] mr_next;
    logic zq_first_reg;
    logic zq_first_next;
    logic taken;
    logic illegal;
    logic burst_reg;
    logic refresh_reg;
    logic zq_busy_reg;
    logic cal_apply_reg;
    logic idle_reg;
    logic taken_reg;
    logic illegal_reg;

    sck_timer_bank u_tmr (
        .clk_i(CLK_I),
        .rst_n_i(DRAM_RST_N_I),
        .srst_i(SYS_RST_I),
        .tb(tmr_bus.tmr)
    );

    assign cmd = decode_cmd(CS_N_I, RAS_N_I, CAS_N_I, WE_N_I, ADDR_I[A10_POS]);
    assign desnop = (cmd == CMD_DES) || (cmd == CMD_NOP);
    assign all_idle = (bank_reg == BANK_RST) && (tmr_bus.busy == '0);

    always_comb
    begin
        st_next = st_reg;
        bank_next = bank_reg;
        ap_next = ap_reg;
        mr_next = mr_reg;
        zq_first_next = zq_first_reg;
        taken = 1'b0;
        illegal = 1'b0;
        tmr_bus.start = '0;
        tmr_bus.load[TMR_BURST] = BURST_CYC;
        tmr_bus.load[TMR_PRE] = TRP_CYC;
        tmr_bus.load[TMR_REF] = TRFC_CYC;
        tmr_bus.load[TMR_ZQ] = zq_first_reg ? ZQOPER_CYC : ZQINIT_CYC;
        tmr_bus.load[TMR_EXIT] = (st_reg == PWR_SREF) ? TXS_CYC : TXP_CYC;
        // Auto precharge closes its bank when the burst's last clock passes.
        if (tmr_bus.done[TMR_BURST] && (ap_reg != BANK_RST))
        begin
            bank_next = bank_next & ~ap_reg;
            ap_next = BANK_RST;
            tmr_bus.start[TMR_PRE] = 1'b1;
        end
        case (st_reg)
            PWR_NORMAL:
            begin
                if (!cke_prev_reg)
                begin
                    illegal = 1'b1;
                end
                else if (!CKE_I)
                begin
                    if (desnop)
                    begin
                        if (bank_reg != BANK_RST)
                        begin
                            st_next = PWR_PD_ACTIVE;
                        end
                        else if (tmr_bus.busy[TMR_BURST] || tmr_bus.busy[TMR_PRE])
                        begin
                            st_next = PWR_PD;
                        end
                        else
                        begin
                            st_next = PWR_PD_PRECH;
                        end
                    end
                    else if ((cmd == CMD_REF) && all_idle)
                    begin
                        st_next = PWR_SREF;
                        taken = 1'b1;
                    end
                    else
                    begin
                        illegal = 1'b1;
                    end
                end
                else if (tmr_bus.busy[TMR_ZQ] && !desnop)
                begin
                    illegal = 1'b1;
                end
                else
                begin
                    case (cmd)
                        CMD_MRS:
                        begin
                            if (all_idle)
                            begin
                                mr_next[BA_I[MR_SEL_W-1:0]] = ADDR_I;
                                taken = 1'b1;
                            end
                            else
                            begin
                                illegal = 1'b1;
                            end
                        end
                        CMD_REF:
                        begin
                            if (all_idle)
                            begin
                                tmr_bus.start[TMR_REF] = 1'b1;
                                taken = 1'b1;
                            end
                            else
                            begin
                                illegal = 1'b1;
                            end
                        end
                        CMD_PRE:
                        begin
                            if (ADDR_I[A10_POS])
                            begin
                                bank_next = BANK_RST;
                            end
                            else
                            begin
                                bank_next[BA_I] = 1'b0;
                            end
                            tmr_bus.start[TMR_PRE] = 1'b1;
                            taken = 1'b1;
                        end
                        CMD_ACT:
                        begin
                            if (!bank_reg[BA_I] && !tmr_bus.busy[TMR_PRE] &&
                                !tmr_bus.busy[TMR_REF] && !tmr_bus.busy[TMR_EXIT])
                            begin
                                bank_next[BA_I] = 1'b1;
                                taken = 1'b1;
                            end
                            else
                            begin
                                illegal = 1'b1;
                            end
                        end
                        CMD_WR, CMD_RD:
                        begin
                            if (bank_reg[BA_I] && !tmr_bus.busy[TMR_BURST])
                            begin
                                tmr_bus.start[TMR_BURST] = 1'b1;
                                ap_next[BA_I] = ADDR_I[A10_POS];
                                taken = 1'b1;
                            end
                            else
                            begin
                                illegal = 1'b1;
                            end
                        end
                        CMD_ZQCL:
                        begin
                            if ((bank_reg == BANK_RST) && !tmr_bus.busy[TMR_BURST])
                            begin
                                tmr_bus.start[TMR_ZQ] = 1'b1;
                                zq_first_next = 1'b1;
                                taken = 1'b1;
                            end
                            else
                            begin
                                illegal = 1'b1;
                            end
                        end
                        CMD_ZQCS:
                        begin
                            taken = 1'b1;
                        end
                        default:
                        begin
                            taken = 1'b0;
                        end
                    endcase
                end
            end
            PWR_PD_ACTIVE, PWR_PD, PWR_PD_PRECH:
            begin
                if (CKE_I)
                begin
                    if (desnop)
                    begin
                        st_next = PWR_NORMAL;
                        tmr_bus.start[TMR_EXIT] = 1'b1;
                    end
                    else
                    begin
                        illegal = 1'b1;
                    end
                end
            end
            PWR_SREF:
            begin
                // unqualified exit
                // The synchroniser still holds the high level from before entry.
                // Exit therefore waits for a fresh rise of the synchronised enable.
                if (cke_sync_reg && !cke_sync_d_reg)
                begin
                    st_next = PWR_NORMAL;
                    tmr_bus.start[TMR_EXIT] = 1'b1;
                end
            end
            default:
            begin
                st_next = PWR_NORMAL;
                illegal = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge DRAM_RST_N_I)
    begin
        if (!DRAM_RST_N_I)
        begin
            st_reg <= PWR_NORMAL;
            cke_sync_d_reg <= 1'b0;
            bank_reg <= BANK_RST;
            ap_reg <= BANK_RST;
            mr_reg <= '0;
            zq_first_reg <= 1'b0;
            cke_prev_reg <= 1'b0;
            cke_meta_reg <= 1'b0;
            cke_sync_reg <= 1'b0;
            burst_reg <= 1'b0;
            refresh_reg <= 1'b0;
            zq_busy_reg <= 1'b0;
            cal_apply_reg <= 1'b0;
            idle_reg <= 1'b0;
            taken_reg <= 1'b0;
            illegal_reg <= 1'b0;
        end
        else if (SYS_RST_I)
        begin
            st_reg <= PWR_NORMAL;
            cke_sync_d_reg <= 1'b0;
            bank_reg <= BANK_RST;
            ap_reg <= BANK_RST;
            mr_reg <= '0;
            zq_first_reg <= 1'b0;
            cke_prev_reg <= 1'b0;
            cke_meta_reg <= 1'b0;
            cke_sync_reg <= 1'b0;
            burst_reg <= 1'b0;
            refresh_reg <= 1'b0;
            zq_busy_reg <= 1'b0;
            cal_apply_reg <= 1'b0;
            idle_reg <= 1'b0;
            taken_reg <= 1'b0;
            illegal_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            bank_reg <= bank_next;
            ap_reg <= ap_next;
            mr_reg <= mr_next;
            zq_first_reg <= zq_first_next;
            cke_prev_reg <= CKE_I;
            cke_meta_reg <= CKE_I;
            cke_sync_reg <= cke_meta_reg;
            cke_sync_d_reg <= cke_sync_reg;
            burst_reg <= tmr_bus.busy[TMR_BURST];
            refresh_reg <= tmr_bus.busy[TMR_REF];
            zq_busy_reg <= tmr_bus.busy[TMR_ZQ];
            cal_apply_reg <= tmr_bus.done[TMR_ZQ];
            idle_reg <= all_idle && CKE_I && (st_reg == PWR_NORMAL);
            taken_reg <= taken;
            illegal_reg <= illegal;
        end
    end

    assign PWR_STATE_O = st_reg;
    assign BANK_OPEN_O = bank_reg;
    assign BURST_ACT_O = burst_reg;
    assign REFRESH_ACT_O = refresh_reg;
    assign ZQ_BUSY_O = zq_busy_reg;
    assign CAL_APPLY_O = cal_apply_reg;
    assign IDLE_O = idle_reg;
    assign CMD_TAKEN_O = taken_reg;
    assign ILLEGAL_O = illegal_reg;
    assign MODE_REG_O = mr_reg;

    // Helper that measures each calibration window.
    logic [TMR_W-1:0] zq_len_reg;
    logic [TMR_W-1:0] zq_exp_reg;
    always_ff @(posedge CLK_I)
    begin
        if (tmr_bus.start[TMR_ZQ])
        begin
            zq_len_reg <= TMR_RST;
            zq_exp_reg <= tmr_bus.load[TMR_ZQ];
        end
        else if (tmr_bus.busy[TMR_ZQ])
        begin
            zq_len_reg <= zq_len_reg + 16'h0001;
        end
    end

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SYS_RST_I || !DRAM_RST_N_I);

    a_nop_keeps_banks: assert property (
        (st_reg == PWR_NORMAL) && cke_prev_reg && CKE_I && desnop && (ap_reg == BANK_RST)
        |=> $stable(bank_reg) && !CMD_TAKEN_O)
        else $error("NOP or deselect changed bank state");
    a_burst_full_length: assert property (
        tmr_bus.start[TMR_BURST] |=> tmr_bus.busy[TMR_BURST] [*4] ##1 !tmr_bus.busy[TMR_BURST])
        else $error("burst length not four clocks");
    a_sref_entry_ref: assert property (
        (st_reg == PWR_NORMAL) && cke_prev_reg && !CKE_I && (cmd == CMD_REF) && all_idle
        |=> PWR_STATE_O == PWR_SREF)
        else $error("self refresh not entered");
    a_pd_kind_chosen: assert property (
        (st_reg == PWR_NORMAL) && cke_prev_reg && !CKE_I && desnop && (bank_reg != BANK_RST)
        |=> PWR_STATE_O == PWR_PD_ACTIVE)
        else $error("active power-down not entered");
    a_pd_hold_low: assert property (
        (st_reg inside {PWR_PD_ACTIVE, PWR_PD, PWR_PD_PRECH}) && !CKE_I |=> $stable(st_reg))
        else $error("power-down left with clock enable low");
    a_pd_exit_bad: assert property (
        (st_reg inside {PWR_PD_ACTIVE, PWR_PD, PWR_PD_PRECH}) && CKE_I && !desnop
        |=> ILLEGAL_O && $stable(st_reg))
        else $error("illegal exit command not flagged");
    a_sref_exit_async: assert property (
        (st_reg == PWR_SREF) && cke_sync_reg && !cke_sync_d_reg
        |=> (st_reg == PWR_NORMAL) && tmr_bus.busy[TMR_EXIT])
        else $error("self refresh exit missed");
    a_no_pd_refresh: assert property (
        (st_reg != PWR_NORMAL) |-> !tmr_bus.start[TMR_REF])
        else $error("refresh started outside normal state");
    a_zq_window_len: assert property (
        $fell(tmr_bus.busy[TMR_ZQ]) |-> (zq_len_reg == zq_exp_reg) &&
        ((zq_exp_reg == ZQINIT_CYC) || (zq_exp_reg == ZQOPER_CYC)))
        else $error("calibration window length wrong");
    a_zq_apply_end: assert property (
        $fell(tmr_bus.busy[TMR_ZQ]) |-> CAL_APPLY_O ##1 !CAL_APPLY_O)
        else $error("calibration results not applied at window end");
    a_mrs_selects: assert property (
        taken && (cmd == CMD_MRS) |=> mr_reg[$past(BA_I[MR_SEL_W-1:0])] == $past(ADDR_I))
        else $error("mode register write went astray");
    a_idle_means: assert property (
        IDLE_O |-> ($past(bank_reg) == BANK_RST) && !BURST_ACT_O && !REFRESH_ACT_O)
        else $error("idle shown while busy");

    c_sref_entered: cover property ($rose(st_reg == PWR_SREF));
    c_pd_active: cover property ($rose(st_reg == PWR_PD_ACTIVE));
    c_zq_done: cover property (CAL_APPLY_O);
    c_burst_ap: cover property (tmr_bus.done[TMR_BURST] && (ap_reg != BANK_RST));

endmodule : sck_cmd_state
`default_nettype wire

/* File: sck_ctrl_model.sv */
// Controller model: drives clock enable and the command pins of the core.
// Assumes one caller at a time; each call stands for exactly one edge.
`timescale 1ns/1ps
`default_nettype none
module sck_ctrl_model (
    input wire logic clk_i,
    output logic cke_o,
    output logic [3:0] cmd_o,
    output logic [2:0] ba_o,
    output logic [15:0] addr_o
);
    initial
    begin
        cke_o = 1'b1;
        cmd_o = 4'h7;
        ba_o = 3'h5;
        addr_o = 16'h0000;
    end

    // one command per edge
    // The command is {cs, ras, cas, we} and is held until the next call.
    task automatic send(input logic cke, input logic [3:0] cmd, input logic [2:0] ba,
                        input logic [15:0] addr);
        @(posedge clk_i);
        cke_o <= cke;
        cmd_o <= cmd;
        ba_o <= ba;
        addr_o <= addr;
    endtask : send
endmodule : sck_ctrl_model
`default_nettype wire

/* File: sdram_cke_command_state_logic_bench.sv */
// Bench of the command and power-state logic; scenarios run in order.
// Assumes the controller model drives the command pins.
`timescale 1ns/1ps
`default_nettype none
module sdram_cke_command_state_logic_bench;
    import sck_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic rst_n = 1'b1;
    logic cke;
    logic [3:0] cmd;
    logic [2:0] ba;
    logic [15:0] addr;
    sck_pwr_t pwr;
    logic [7:0] bank;
    logic burst, refr, zq, apply, idle, taken, ill;
    logic [63:0] mr;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;

    initial
    begin
        forever #50 clk = ~clk;
    end

    sck_ctrl_model m (.clk_i(clk), .cke_o(cke), .cmd_o(cmd), .ba_o(ba), .addr_o(addr));

    sck_cmd_state uut (.CLK_I(clk), .SYS_RST_I(srst), .DRAM_RST_N_I(rst_n), .CKE_I(cke),
        .CS_N_I(cmd[3]), .RAS_N_I(cmd[2]), .CAS_N_I(cmd[1]), .WE_N_I(cmd[0]), .BA_I(ba),
        .ADDR_I(addr), .PWR_STATE_O(pwr), .BANK_OPEN_O(bank), .BURST_ACT_O(burst),
        .REFRESH_ACT_O(refr), .ZQ_BUSY_O(zq), .CAL_APPLY_O(apply), .IDLE_O(idle),
        .CMD_TAKEN_O(taken), .ILLEGAL_O(ill), .MODE_REG_O(mr));

    task automatic results();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
        begin
            $display("TEST PASSED");
        end
        else
        begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            results();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Outputs seen after a step answer the command of the step before.
    task automatic step(input logic k, input logic [3:0] c, input logic [15:0] a = 16'h0000);
        m.send(k, c, 3'h5, a);
        #1;
    endtask : step

    task automatic t_zq(input int len);
        int n;
        n = 0;
        step(1, 4'h6, 16'h0400);
        step(1, 4'h7);
        chk(taken, 1'b1);
        while (apply !== 1'b1 && n < 600)
        begin
            step(1, 4'h7);
            n++;
        end
        chk(64'(n), 64'(len));
        chk(zq, 1'b1);
    endtask : t_zq

    task automatic t_read();
        step(1, 4'h3);
        step(1, 4'h5, 16'h0400);
        chk(taken, 1'b1);
        chk(bank, 8'h20);
        step(1, 4'h4, 16'h0400);
        chk(taken, 1'b1);
        step(1, 4'h7);
        chk(ill, 1'b1);
        step(1, 4'h7);
        chk(burst, 1'b1);
        repeat (5) step(1, 4'h7);
        chk({burst, bank}, 9'h000);
    endtask : t_read

    task automatic t_mrs_des();
        step(1, 4'h0, 16'h1234);
        step(1, 4'h7);
        chk(taken, 1'b1);
        chk(mr, 64'h0000_0000_1234_0000);
        step(1, 4'h1);
        step(1, 4'h7);
        chk(taken, 1'b1);
        step(1, 4'h7);
        chk(refr, 1'b1);
        step(1, 4'hB);
        step(1, 4'h7);
        chk({taken, bank}, 9'h000);
        step(1, 4'h7);
        chk({taken, bank}, 9'h000);
    endtask : t_mrs_des

    task automatic t_pd();
        step(1, 4'h3);
        step(0, 4'h7);
        step(0, 4'h7);
        chk(pwr, PWR_PD_ACTIVE);
        step(1, 4'h7);
        step(1, 4'h7);
        chk(pwr, PWR_NORMAL);
        step(1, 4'h7);
        step(1, 4'h2, 16'h0400);
        repeat (2) step(1, 4'h7);
        step(0, 4'h7);
        step(0, 4'h1);
        chk(pwr, PWR_PD_PRECH);
        step(0, 4'h7);
        chk({refr, pwr}, {1'b0, PWR_PD_PRECH});
        step(1, 4'h7);
        step(1, 4'h7);
        chk({pwr, bank}, {PWR_NORMAL, 8'h00});
    endtask : t_pd

    task automatic t_sref();
        int n;
        n = 0;
        repeat (2) step(1, 4'h7);
        step(0, 4'h1);
        step(0, 4'h7);
        chk(pwr, PWR_SREF);
        while (pwr !== PWR_NORMAL && n < 10)
        begin
            step(1, 4'h7);
            n++;
        end
        chk(pwr, PWR_NORMAL);
        repeat (8) step(1, 4'h7);
    endtask : t_sref

    task automatic t_arst();
        step(1, 4'h3);
        step(1, 4'h7);
        chk(bank, 8'h20);
        @(posedge clk);
        rst_n <= 1'b0;
        #1;
        chk({pwr, bank}, {PWR_NORMAL, 8'h00});
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) step(1, 4'h7);
    endtask : t_arst

    initial
    begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        repeat (3) step(1, 4'h7);
        chk(pwr, PWR_NORMAL);
        chk(idle, 1'b1);
        t_zq(ZQINIT_NS / CLK_PERIOD_NS);
        t_read();
        t_mrs_des();
        t_pd();
        t_sref();
        t_zq(ZQOPER_NS / CLK_PERIOD_NS);
        t_arst();
        t_zq(ZQINIT_NS / CLK_PERIOD_NS);
        results();
    end
endmodule : sdram_cke_command_state_logic_bench
`default_nettype wire
